// *** design/cpl_pkg.sv ***
// Palette lookup package: register map, fields, modes and carriers
package cpl_pkg;
  localparam logic [7:0] PALETTE_INDEX_OFS = 8'h15;
  localparam logic [7:0] PALETTE_COMPONENT_DATA_OFS = 8'h17;
  localparam logic [7:0] DISPLAY_MODE_OFS = 8'h18;
  localparam logic [7:0] PALETTE_INDEX_RESET = 8'h00;
  localparam logic [1:0] DEPTH_MODE_RESET = 2'h0;
  localparam int COMPONENT_LSB = 4;
  localparam int MODE_DEPTH_LSB = 0;
  localparam int MODE_MONO_BIT = 2;
  localparam int MODE_REFUSED_BIT = 3;

  typedef enum logic [1:0] {
    CPL_BPP1 = 2'h0,
    CPL_BPP2 = 2'h1,
    CPL_BPP4 = 2'h2,
    CPL_BPP8 = 2'h3
  } cpl_depth_e;

  typedef enum logic [2:0] {
    CPL_SEL_RED = 3'b001,
    CPL_SEL_GREEN = 3'b010,
    CPL_SEL_BLUE = 3'b100
  } cpl_sel_e;

  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } cpl_rgb_s;
endpackage : cpl_pkg

// *** design/cpl_palette.sv ***
// Palette lookup table with Wishbone register access and pixel lookup
//
// How it works
// - The table holds 256 entries with separate red, green and blue parts.
// - Each part is four bits, sixteen levels, 4096 colors per entry.
// - Color modes output the stored red, green and blue of the pixel entry.
// - Monochrome modes use only the green part for all three outputs.
// - Depth limits the entries used: two, four, sixteen or all 256.
// - Host writes the eight-bit index; data accesses go to that entry.
// - Data accesses reach red, then green, then blue.
// - After the third data access the index steps by one, back to red.
// - Writing the index returns the part selector to red.
// - The part value sits in the upper four bits of the data register.
// - One-bit mode: pixel bit zero shows entry zero, one shows entry one.
// - Two-bit mode: pixel values 0 to 3 select entries 0 to 3.
// - Eight-bit depth is refused on monochrome panels.
`timescale 1ns/100ps
module cpl_palette
  import cpl_pkg::*;
#(
  parameter int ENTRIES = 256,
  parameter int COMP_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pixelValid,
  input wire logic [7:0] pixelValue,
  output cpl_rgb_s pixelColor,
  output logic pixelColorValid
);

  if (ENTRIES != 256 || COMP_W != 4) begin : g_size_check
    $error("cpl_palette supports only 256 entries of 4-bit parts");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  cpl_rgb_s table_mem [ENTRIES];
  logic [7:0] palette_index;
  cpl_sel_e compSel;
  cpl_depth_e depthMode;
  logic monoMode;
  logic depthRefused;
  logic ack;
  logic [7:0] rdData;
  logic [7:0] next_palette_index;
  cpl_sel_e next_compSel;
  cpl_depth_e next_depthMode;
  logic next_monoMode;
  logic next_depthRefused;
  logic next_ack;
  logic [7:0] next_rdData;
  logic busReq;
  logic dataAcc;
  logic [COMP_W-1:0] selPart;
  cpl_rgb_s curEntry;

  assign busReq = wb_cyc_i && wb_stb_i && !ack;
  assign dataAcc = busReq && wb_adr_i == PALETTE_COMPONENT_DATA_OFS;
  assign curEntry = table_mem[palette_index];
  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;
  assign selPart = wb_dat_i[COMPONENT_LSB +: COMP_W];

  always_comb begin
    next_palette_index = palette_index;
    next_compSel = compSel;
    next_depthMode = depthMode;
    next_monoMode = monoMode;
    next_depthRefused = depthRefused;
    next_ack = busReq;
    next_rdData = 8'h00;
    if (busReq) begin
      if (wb_adr_i == PALETTE_INDEX_OFS) begin
        next_rdData = palette_index;
        if (wb_we_i && wb_sel_i) begin
          next_palette_index = wb_dat_i;
          next_compSel = CPL_SEL_RED;
        end
      end else if (dataAcc) begin
        unique case (compSel)
          CPL_SEL_RED: begin
            next_rdData = {curEntry.red, 4'h0};
            next_compSel = CPL_SEL_GREEN;
          end
          CPL_SEL_GREEN: begin
            next_rdData = {curEntry.green, 4'h0};
            next_compSel = CPL_SEL_BLUE;
          end
          CPL_SEL_BLUE: begin
            next_rdData = {curEntry.blue, 4'h0};
            next_compSel = CPL_SEL_RED;
            next_palette_index = 8'(palette_index + 8'h01);
          end
        endcase
      end else if (wb_adr_i == DISPLAY_MODE_OFS) begin
        next_rdData = {4'h0, depthRefused, monoMode, depthMode};
        if (wb_we_i && wb_sel_i) begin
          next_monoMode = wb_dat_i[MODE_MONO_BIT];
          if (wb_dat_i[MODE_MONO_BIT] && wb_dat_i[MODE_DEPTH_LSB +: 2] == CPL_BPP8) begin
            next_depthMode = CPL_BPP4;
            next_depthRefused = 1'b1;
          end else begin
            next_depthMode = cpl_depth_e'(wb_dat_i[MODE_DEPTH_LSB +: 2]);
            next_depthRefused = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      palette_index <= PALETTE_INDEX_RESET;
      compSel <= CPL_SEL_RED;
      depthMode <= cpl_depth_e'(DEPTH_MODE_RESET);
      monoMode <= 1'b0;
      depthRefused <= 1'b0;
      ack <= 1'b0;
      rdData <= 8'h00;
    end else begin
      palette_index <= next_palette_index;
      compSel <= next_compSel;
      depthMode <= next_depthMode;
      monoMode <= next_monoMode;
      depthRefused <= next_depthRefused;
      ack <= next_ack;
      rdData <= next_rdData;
    end
  end

  // Table storage, no reset so it maps to RAM
  always_ff @(posedge ref_clk) begin
    if (dataAcc && wb_we_i && wb_sel_i) begin
      unique case (compSel)
        CPL_SEL_RED: table_mem[palette_index].red <= selPart;
        CPL_SEL_GREEN: table_mem[palette_index].green <= selPart;
        CPL_SEL_BLUE: table_mem[palette_index].blue <= selPart;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel lookup
  logic [7:0] lookIndex;
  cpl_rgb_s lookEntry;
  cpl_rgb_s next_pixelColor;
  logic next_pixelColorValid;

  always_comb begin
    unique case (depthMode)
      CPL_BPP1: lookIndex = {7'h00, pixelValue[0]};
      CPL_BPP2: lookIndex = {6'h00, pixelValue[1:0]};
      CPL_BPP4: lookIndex = {4'h0, pixelValue[3:0]};
      CPL_BPP8: lookIndex = pixelValue;
    endcase
    lookEntry = table_mem[lookIndex];
    next_pixelColorValid = pixelValid;
    next_pixelColor = pixelColor;
    if (pixelValid) begin
      if (monoMode) begin
        next_pixelColor = '{red: lookEntry.green, green: lookEntry.green, blue: lookEntry.green};
      end else begin
        next_pixelColor = lookEntry;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pixelColor <= '0;
      pixelColorValid <= 1'b0;
    end else begin
      pixelColor <= next_pixelColor;
      pixelColorValid <= next_pixelColorValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_blue_access;
    dataAcc && compSel == CPL_SEL_BLUE;
  endsequence
  sequence s_red_access;
    dataAcc && compSel == CPL_SEL_RED;
  endsequence
  sequence s_green_access;
    dataAcc && compSel == CPL_SEL_GREEN;
  endsequence
  sequence s_index_write;
    busReq && wb_we_i && wb_sel_i && wb_adr_i == PALETTE_INDEX_OFS;
  endsequence
  sequence s_data_write;
    dataAcc && wb_we_i && wb_sel_i;
  endsequence
  sequence s_mode_write;
    busReq && wb_we_i && wb_sel_i && wb_adr_i == DISPLAY_MODE_OFS;
  endsequence

  a_index_step: assert property (@(posedge ref_clk) disable iff (rst)
    s_blue_access |=> palette_index == 8'($past(palette_index) + 8'h01) && compSel == CPL_SEL_RED)
    else $error("index did not step after blue");
  a_part_order: assert property (@(posedge ref_clk) disable iff (rst)
    s_red_access |=> compSel == CPL_SEL_GREEN)
    else $error("red not followed by green");
  a_green_blue: assert property (@(posedge ref_clk) disable iff (rst)
    s_green_access |=> compSel == CPL_SEL_BLUE && $stable(palette_index))
    else $error("green not followed by blue");
  a_index_write: assert property (@(posedge ref_clk) disable iff (rst)
    s_index_write
    |=> compSel == CPL_SEL_RED && palette_index == $past(wb_dat_i))
    else $error("index write did not reset selector");
  a_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $past(dataAcc) |-> wb_ack_o && wb_dat_o[3:0] == 4'h0)
    else $error("low data bits not zero");
  a_wrap_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (s_blue_access and (palette_index == 8'hFF)) |=> palette_index == 8'h00)
    else $error("index did not wrap");
  a_mono_gray: assert property (@(posedge ref_clk) disable iff (rst)
    pixelValid && monoMode |=> pixelColor.red == pixelColor.green && pixelColor.blue == pixelColor.green)
    else $error("mono output not gray");
  a_no_mono8: assert property (@(posedge ref_clk) disable iff (rst)
    !(monoMode && depthMode == CPL_BPP8))
    else $error("eight-bit depth on monochrome");
  a_one_bit: assert property (@(posedge ref_clk) disable iff (rst)
    depthMode == CPL_BPP1 |-> lookIndex[7:1] == 7'h00)
    else $error("one-bit mode reached past entry one");
  a_ack_once: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  // Bus answer and index
  a_ack_answer: assert property (@(posedge ref_clk) disable iff (rst)
    busReq |=> wb_ack_o)
    else $error("request not acknowledged");
  a_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 8'h00)
    else $error("read data not zero without ack");
  a_read_index: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && !wb_we_i && wb_adr_i == PALETTE_INDEX_OFS |=> wb_dat_o == $past(palette_index))
    else $error("index read back wrong");
  a_index_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !(busReq && wb_adr_i == PALETTE_INDEX_OFS) && !dataAcc |=> $stable(palette_index))
    else $error("index moved without access");
  // Table store and read back
  a_red_store: assert property (@(posedge ref_clk) disable iff (rst)
    (s_data_write and s_red_access) |=> table_mem[$past(palette_index)].red == $past(selPart))
    else $error("red part not stored");
  a_green_store: assert property (@(posedge ref_clk) disable iff (rst)
    (s_data_write and s_green_access) |=> table_mem[$past(palette_index)].green == $past(selPart))
    else $error("green part not stored");
  a_blue_store: assert property (@(posedge ref_clk) disable iff (rst)
    (s_data_write and s_blue_access) |=> table_mem[$past(palette_index)].blue == $past(selPart))
    else $error("blue part not stored");
  a_read_red: assert property (@(posedge ref_clk) disable iff (rst)
    (s_red_access and !wb_we_i) |=> wb_dat_o == {$past(curEntry.red), 4'h0})
    else $error("red read wrong");
  a_read_green: assert property (@(posedge ref_clk) disable iff (rst)
    (s_green_access and !wb_we_i) |=> wb_dat_o == {$past(curEntry.green), 4'h0})
    else $error("green read wrong");
  a_read_blue: assert property (@(posedge ref_clk) disable iff (rst)
    (s_blue_access and !wb_we_i) |=> wb_dat_o == {$past(curEntry.blue), 4'h0})
    else $error("blue read wrong");
  // Pixel path and mode register
  a_pix_valid: assert property (@(posedge ref_clk) disable iff (rst)
    pixelValid |=> pixelColorValid)
    else $error("pixel valid not passed on");
  a_pix_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !pixelValid |=> !pixelColorValid)
    else $error("pixel valid without pixel");
  a_color_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !pixelValid |=> $stable(pixelColor))
    else $error("color changed without pixel");
  a_color_lookup: assert property (@(posedge ref_clk) disable iff (rst)
    pixelValid && !monoMode |=> pixelColor == $past(lookEntry))
    else $error("color not from table entry");
  a_mono_green: assert property (@(posedge ref_clk) disable iff (rst)
    pixelValid && monoMode |=> pixelColor.green == $past(lookEntry.green))
    else $error("mono level not from green part");
  a_two_bit: assert property (@(posedge ref_clk) disable iff (rst)
    depthMode == CPL_BPP2 |-> lookIndex[7:2] == 6'h00)
    else $error("two-bit mode reached past entry three");
  a_four_bit: assert property (@(posedge ref_clk) disable iff (rst)
    depthMode == CPL_BPP4 |-> lookIndex[7:4] == 4'h0)
    else $error("four-bit mode reached past entry fifteen");
  a_mode_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    (s_mode_write and (wb_dat_i[MODE_MONO_BIT] && wb_dat_i[MODE_DEPTH_LSB +: 2] == CPL_BPP8))
    |=> depthMode == CPL_BPP4 && depthRefused)
    else $error("eight-bit depth not refused on monochrome");
  a_mode_store: assert property (@(posedge ref_clk) disable iff (rst)
    (s_mode_write and !(wb_dat_i[MODE_MONO_BIT] && wb_dat_i[MODE_DEPTH_LSB +: 2] == CPL_BPP8))
    |=> depthMode == $past(wb_dat_i[MODE_DEPTH_LSB +: 2]) && !depthRefused)
    else $error("depth not stored");

endmodule : cpl_palette

// *** dv/cpl_host_model.sv ***
// Host model: classic Wishbone master for palette register access
`timescale 1ns/100ps
module cpl_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] datR,
  input wire logic ack,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [7:0] datW,
  output logic sel,
  output logic hung
);
  initial begin
    {cyc, stb, we, adr, datW, sel, hung} = '0;
  end
  // Released address and data lines show inverted values, cyc, stb and we drop to zero
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, datW, sel} <= {1'b1, 1'b1, w, a, d, 1'b1};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = datR;
    hung = hung | (ack !== 1'b1);
    {cyc, stb, we, adr, datW} <= {3'b000, ~a, ~d};
  endtask : xfer
endmodule : cpl_host_model

// *** dv/tb_color_palette_lookup.sv ***
// Testbench for the palette lookup block
`timescale 1ns/100ps
module tb_color_palette_lookup;
  import cpl_pkg::*;
  logic ref_clk, rst, cyc, stb, we, sel, ack, hung, pixelValid, pixelColorValid;
  logic [7:0] adr, datW, datR, pixelValue, rd;
  cpl_rgb_s pixelColor;
  int errors = 0;
  int tests_run = 0;
  cpl_palette u_cpl_palette (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack), .pixelValid(pixelValid),
    .pixelValue(pixelValue), .pixelColor(pixelColor), .pixelColorValid(pixelColorValid));
  cpl_host_model u_cpl_host_model (.ref_clk(ref_clk), .datR(datR), .ack(ack), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .datW(datW), .sel(sel), .hung(hung));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic cpl_rgb_s ent(input logic [7:0] e);
    ent = (e == 8'h00) ? 12'h000 : (e == 8'h01) ? 12'hFFF : {e[3:0], e[7:4] ^ 4'h3, ~e[3:0]};
  endfunction : ent
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_cpl_host_model.xfer(w, a, d, rd);
    if (hung) begin
      errors++;
      final_report();
    end
  endtask : acc
  // Low nibble written as junk, must read back zero
  task automatic load(input logic [7:0] e);
    cpl_rgb_s v;
    v = ent(e);
    acc(1'b1, PALETTE_INDEX_OFS, e);
    acc(1'b1, PALETTE_COMPONENT_DATA_OFS, {v.red, 4'hF});
    acc(1'b1, PALETTE_COMPONENT_DATA_OFS, {v.green, 4'hA});
    acc(1'b1, PALETTE_COMPONENT_DATA_OFS, {v.blue, 4'h5});
  endtask : load
  task automatic rdent(input logic [7:0] e, input int k);
    cpl_rgb_s v;
    acc(1'b1, PALETTE_INDEX_OFS, e);
    for (int i = 0; i < k; i++) begin
      acc(1'b0, PALETTE_COMPONENT_DATA_OFS, 8'h00);
      v = ent(8'(e + 8'(i / 3)));
      chk(12'(rd), 12'({v[11 - 4 * (i % 3) -: 4], 4'h0}));
    end
    acc(1'b0, PALETTE_INDEX_OFS, 8'h00);
    chk(12'(rd), 12'(8'(e + 8'(k / 3))));
  endtask : rdent
  task automatic t_regs;
    logic [7:0] ents [6];
    ents = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'hFF};
    foreach (ents[i]) load(ents[i]);
    rdent(8'h00, 6);
    rdent(8'hFF, 3);
    $display("test regs done");
  endtask : t_regs
  task automatic t_sel;
    acc(1'b1, PALETTE_INDEX_OFS, 8'h02);
    acc(1'b0, PALETTE_COMPONENT_DATA_OFS, 8'h00);
    acc(1'b0, PALETTE_COMPONENT_DATA_OFS, 8'h00);
    acc(1'b1, PALETTE_INDEX_OFS, 8'h02);
    acc(1'b0, PALETTE_COMPONENT_DATA_OFS, 8'h00);
    chk(12'(rd), 12'({ent(8'h02) >> 8, 4'h0}));
    acc(1'b0, 8'h20, 8'h00);
    chk(12'(rd), 12'h000);
    $display("test selector done");
  endtask : t_sel
  // Host turns wide intensities into four-bit parts
  task automatic t_conv;
    logic [7:0] wide [3];
    logic [5:0] legacy [3];
    logic [7:0] want [6];
    wide = '{8'hA7, 8'h3C, 8'hF1};
    legacy = '{6'h3F, 6'h20, 6'h05};
    want = '{8'hA0, 8'h30, 8'hF0, 8'hF0, 8'h80, 8'h10};
    acc(1'b1, PALETTE_INDEX_OFS, 8'h40);
    foreach (wide[i]) acc(1'b1, PALETTE_COMPONENT_DATA_OFS, {wide[i][7:4], 4'h0});
    foreach (legacy[i]) acc(1'b1, PALETTE_COMPONENT_DATA_OFS, {4'(legacy[i] / 6'h04), 4'h0});
    acc(1'b1, PALETTE_INDEX_OFS, 8'h40);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, PALETTE_COMPONENT_DATA_OFS, 8'h00);
      chk(12'(rd), 12'(want[i]));
    end
    $display("test conversion done");
  endtask : t_conv
  task automatic pix(input logic [7:0] m, input logic [7:0] p, input logic [7:0] e);
    cpl_rgb_s v;
    v = ent(e);
    if (m[MODE_MONO_BIT]) v = {v.green, v.green, v.green};
    acc(1'b1, DISPLAY_MODE_OFS, m);
    @(posedge ref_clk);
    pixelValid <= 1'b1;
    pixelValue <= p;
    @(posedge ref_clk);
    pixelValid <= 1'b0;
    pixelValue <= ~p;
    @(negedge ref_clk);
    chk(12'(pixelColorValid), 12'h001);
    chk(pixelColor, v);
    @(negedge ref_clk);
    chk(12'(pixelColorValid), 12'h000);
    chk(pixelColor, v);
  endtask : pix
  task automatic t_pix;
    pix(8'h00, 8'hFE, 8'h00);
    pix(8'h00, 8'h01, 8'h01);
    pix(8'h01, 8'hFF, 8'h03);
    pix(8'h01, 8'hFE, 8'h02);
    pix(8'h02, 8'hFF, 8'h0F);
    pix(8'h03, 8'hFF, 8'hFF);
    pix(8'h05, 8'h02, 8'h02);
    pix(8'h07, 8'hFF, 8'h0F);
    acc(1'b0, DISPLAY_MODE_OFS, 8'h00);
    chk(12'(rd), 12'h00E);
    $display("test pixels done");
  endtask : t_pix
  initial begin
    rst = 1'b1;
    pixelValid = 1'b0;
    pixelValue = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    acc(1'b0, PALETTE_INDEX_OFS, 8'h00);
    chk(12'(rd), 12'(PALETTE_INDEX_RESET));
    t_regs();
    t_sel();
    t_conv();
    t_pix();
    final_report();
  end
endmodule : tb_color_palette_lookup
